// File: design/lsd_regs.vh
// Constants of the serial LED sink driver
`ifndef LSD_REGS_VH
`define LSD_REGS_VH
`define LSD_CHANNELS 16
`define LSD_CHAIN_TAP 8
`define LSD_FIFO_DEPTH 8
`define LSD_FIFO_AW 3
`define LSD_PIN_COUNT 54
`define LSD_MODE_W 3
`define LSD_MODE_GLOBAL 3'h0
`define LSD_MODE_OPEN 3'h1
`define LSD_MODE_SHORT 3'h2
`define LSD_MODE_TEMP 3'h3
`define LSD_MODE_LOWCUR 3'h4
`define LSD_RST_SERIAL_OUT 1'h1
`define LSD_RST_WORD 16'h0000
`endif

// File: design/lsd_sync.v
// Two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module lsd_sync #(
    parameter WIDTH = 1
) (
    input wire clk_sys_i,
    input wire rst_i,
    input wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // First stage feeds only the second stage
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule

// File: design/lsd_fifo.v
// Word FIFO with valid/ready on both sides
`timescale 1ns/1ps
module lsd_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk_sys_i,
    input wire rst_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] count_q;
    wire push;
    wire pop;

    assign in_ready_o = (count_q != DEPTH[AW:0]);
    assign out_valid_o = (count_q != {(AW+1){1'b0}});
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;
    assign out_data_o = mem[rd_q];

    always @(posedge clk_sys_i) begin
        if (push) begin
            mem[wr_q] <= in_data_i;
        end
    end

    // Pointers wrap at DEPTH, which need not be a power of two
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                if (wr_q == DEPTH[AW-1:0] - 1'b1) begin
                    wr_q <= {AW{1'b0}};
                end else begin
                    wr_q <= wr_q + 1'b1;
                end
            end
            if (pop) begin
                if (rd_q == DEPTH[AW-1:0] - 1'b1) begin
                    rd_q <= {AW{1'b0}};
                end else begin
                    rd_q <= rd_q + 1'b1;
                end
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule

// File: design/lsd_top.v
// Serial-input sixteen-channel LED sink driver, digital core
//
// Behaviour
// - outside error mode each serial clock rise shifts serial_in into the shift register.
// - in normal mode serial_out shows a bit 8.5 clocks after capture.
// - sixteen sink outputs, one per channel, follow the displayed pattern.
// - displayed pattern sits in a data register apart from the shifter.
// - data register loads from the queue after a rising transfer edge outside error mode, while hold is low; not while shifting.
// - drive_gate_n low enables all sinks, high disables them.
// - drive_gate_n rules the sinks in every mode, diagnostics included.
// - in error mode each serial clock rise steps to the next mode.
// - global detection mode drives serial_out 0 on error, 1 if clean.
// - load captures global fault and per-channel diagnostic results.
// - low-current diagnostic mode requests reduced test current.
`timescale 1ns/1ps
`include "lsd_regs.vh"
module lsd_top #(
    parameter CHANNELS = `LSD_CHANNELS,
    parameter CHAIN_TAP = `LSD_CHAIN_TAP,
    parameter FIFO_DEPTH = `LSD_FIFO_DEPTH,
    parameter FIFO_AW = `LSD_FIFO_AW
) (
    input wire clk_sys_i,
    input wire rst_i,
    input wire serial_clk_i,
    input wire serial_in_i,
    input wire load_strobe_i,
    input wire drive_gate_n_i,
    input wire error_mode_i,
    input wire hold_i,
    input wire [15:0] fault_open_i,
    input wire [15:0] fault_short_i,
    input wire [15:0] fault_temp_i,
    output reg [15:0] sink_outputs_o,
    output reg serial_out_o,
    output reg load_ready_o,
    output reg low_current_o,
    output reg [2:0] error_mode_o,
    output reg [15:0] diag_result_o
);
    // Rising edge from a sampled level and its previous sample
    function rise;
        input cur;
        input prev;
        begin
            rise = cur & ~prev;
        end
    endfunction

    // Falling edge from a sampled level and its previous sample
    function fall;
        input cur;
        input prev;
        begin
            fall = ~cur & prev;
        end
    endfunction

    // Next diagnostic mode, wrapping after the low-current test
    function [2:0] next_mode;
        input [2:0] mode;
        begin
            if (mode == `LSD_MODE_LOWCUR) begin
                next_mode = `LSD_MODE_GLOBAL;
            end else begin
                next_mode = mode + 3'h1;
            end
        end
    endfunction

    wire [53:0] pins_raw;
    wire [53:0] pins_s;
    wire sclk_s;
    wire sdata_s;
    wire load_s;
    wire gate_n_s;
    wire errm_s;
    wire hold_s;
    wire [15:0] open_s;
    wire [15:0] short_s;
    wire [15:0] temp_s;

    assign pins_raw = {fault_temp_i, fault_short_i, fault_open_i,
                       hold_i, error_mode_i, drive_gate_n_i,
                       load_strobe_i, serial_in_i, serial_clk_i};

    // Pins come from the host's domain and are sampled twice
    lsd_sync #(
        .WIDTH(`LSD_PIN_COUNT)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .async_i(pins_raw),
        .sync_o(pins_s)
    );

    assign sclk_s = pins_s[0];
    assign sdata_s = pins_s[1];
    assign load_s = pins_s[2];
    assign gate_n_s = pins_s[3];
    assign errm_s = pins_s[4];
    assign hold_s = pins_s[5];
    assign open_s = pins_s[21:6];
    assign short_s = pins_s[37:22];
    assign temp_s = pins_s[53:38];

    reg sclk_prev_q;
    reg load_prev_q;
    reg sdata_prev_q;
    wire sclk_rise;
    wire sclk_fall;
    wire load_rise;

    // Serial clock is sampled at 40 MHz, so it must run well below that
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_prev_q <= 1'b0;
            load_prev_q <= 1'b0;
            sdata_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
            load_prev_q <= load_s;
            sdata_prev_q <= sdata_s;
        end
    end

    assign sclk_rise = rise(sclk_s, sclk_prev_q);
    assign sclk_fall = fall(sclk_s, sclk_prev_q);
    assign load_rise = rise(load_s, load_prev_q);

    // Data taken from the sample before the edge, held around it
    reg [CHANNELS-1:0] shift_q;
    reg [CHANNELS-1:0] shift_d;

    always @* begin
        shift_d = shift_q;
        if (sclk_rise && !errm_s) begin
            shift_d = {shift_q[CHANNELS-2:0], sdata_prev_q};
        end
    end

    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            shift_q <= `LSD_RST_WORD;
        end else begin
            shift_q <= shift_d;
        end
    end

    // Error mode: the serial clock steps modes instead of shifting
    reg [2:0] mode_q;
    reg [2:0] mode_d;

    always @* begin
        mode_d = mode_q;
        if (!errm_s) begin
            mode_d = `LSD_MODE_GLOBAL;
        end else if (sclk_rise) begin
            mode_d = next_mode(mode_q);
        end
    end

    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            mode_q <= `LSD_MODE_GLOBAL;
        end else begin
            mode_q <= mode_d;
        end
    end

    // Fault results captured on load while in error mode
    reg glob_err_q;
    reg [CHANNELS-1:0] open_res_q;
    reg [CHANNELS-1:0] short_res_q;
    reg [CHANNELS-1:0] temp_res_q;

    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            glob_err_q <= 1'b0;
            open_res_q <= `LSD_RST_WORD;
            short_res_q <= `LSD_RST_WORD;
            temp_res_q <= `LSD_RST_WORD;
        end else if (load_rise && errm_s) begin
            glob_err_q <= |{open_s, short_s, temp_s};
            open_res_q <= open_s;
            short_res_q <= short_s;
            temp_res_q <= temp_s;
        end
    end

    // Transfer path: load pushes the word, the data register pops it
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire fifo_out_ready;
    wire [CHANNELS-1:0] fifo_out_data;
    wire fifo_push;

    // A load while the FIFO is full is dropped; load_ready_o warns
    assign fifo_push = load_rise & ~errm_s;
    // Hold freezes the display so queued patterns back up
    assign fifo_out_ready = ~hold_s;

    lsd_fifo #(
        .WIDTH(CHANNELS),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .in_valid_i(fifo_push),
        .in_ready_o(fifo_in_ready),
        .in_data_i(shift_q),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    reg [CHANNELS-1:0] data_q;

    // Shifting never touches this register
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            data_q <= `LSD_RST_WORD;
        end else if (fifo_out_valid && fifo_out_ready) begin
            data_q <= fifo_out_data;
        end
    end

    // Gate applied last so no mode can override it
    wire [CHANNELS-1:0] gate_mask;

    assign gate_mask = {CHANNELS{~gate_n_s}};

    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sink_outputs_o <= `LSD_RST_WORD;
        end else begin
            sink_outputs_o <= data_q & gate_mask;
        end
    end

    // Chain output: bit reaches the tap after 8 rises, shown at the fall
    reg chain_q;

    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            chain_q <= `LSD_RST_SERIAL_OUT;
        end else if (sclk_fall) begin
            chain_q <= shift_q[CHAIN_TAP];
        end
    end

    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            serial_out_o <= `LSD_RST_SERIAL_OUT;
        end else if (errm_s && mode_q == `LSD_MODE_GLOBAL) begin
            serial_out_o <= ~glob_err_q;
        // Mode lingers one cycle after the pin drops; keep the line high
        end else if (errm_s || mode_q != `LSD_MODE_GLOBAL) begin
            serial_out_o <= 1'b1;
        end else begin
            serial_out_o <= chain_q;
        end
    end

    // Diagnostic read-back and mode status
    reg [CHANNELS-1:0] diag_d;

    always @* begin
        case (mode_q)
            `LSD_MODE_OPEN: begin
                diag_d = open_res_q;
            end
            `LSD_MODE_SHORT: begin
                diag_d = short_res_q;
            end
            `LSD_MODE_TEMP: begin
                diag_d = temp_res_q;
            end
            default: begin
                diag_d = {{(CHANNELS-1){1'b0}}, glob_err_q};
            end
        endcase
    end

    // Flags follow mode_q so they stay in step with error_mode_o
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            diag_result_o <= `LSD_RST_WORD;
            error_mode_o <= `LSD_MODE_GLOBAL;
            low_current_o <= 1'b0;
            load_ready_o <= 1'b0;
        end else begin
            diag_result_o <= errm_s ? diag_d : `LSD_RST_WORD;
            error_mode_o <= mode_q;
            low_current_o <= (mode_q == `LSD_MODE_LOWCUR);
            load_ready_o <= fifo_in_ready;
        end
    end
endmodule

// File: test/lsd_host.sv
// Host controller model driving serial clock, data and load pins
`timescale 1ns/1ps
module lsd_host (
    input wire clk_sys_i,
    output reg serial_clk_o,
    output reg serial_in_o,
    output reg load_strobe_o
);
    initial begin
        serial_clk_o = 1'b0;
        serial_in_o = 1'b0;
        load_strobe_o = 1'b0;
    end
    // One slow serial clock period, data held well around the rise
    task clk_bit(input b);
        begin
            @(posedge clk_sys_i);
            serial_in_o <= b;
            repeat (4) @(posedge clk_sys_i);
            serial_clk_o <= 1'b1;
            repeat (4) @(posedge clk_sys_i);
            serial_clk_o <= 1'b0;
            // Data window is over, so the line must not keep the old bit
            serial_in_o <= ~b;
        end
    endtask
    // Top bit first, so bit n ends up on channel n
    task send(input [15:0] w);
        integer i;
        begin
            for (i = 15; i >= 0; i = i - 1) begin
                clk_bit(w[i]);
            end
        end
    endtask
    task load;
        begin
            @(posedge clk_sys_i);
            load_strobe_o <= 1'b1;
            repeat (4) @(posedge clk_sys_i);
            load_strobe_o <= 1'b0;
            repeat (12) @(posedge clk_sys_i);
        end
    endtask
endmodule

// File: test/lsd_top_chk.sv
// Port-level assertions for the LED sink driver core
`timescale 1ns/1ps
module lsd_top_chk (
    input wire clk_sys_i,
    input wire rst_i,
    input wire serial_clk_i,
    input wire load_strobe_i,
    input wire drive_gate_n_i,
    input wire error_mode_i,
    input wire hold_i,
    input wire [15:0] sink_outputs_o,
    input wire serial_out_o,
    input wire low_current_o,
    input wire [2:0] error_mode_o,
    input wire [15:0] diag_result_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // Cycles since the last pin event allowed to move an output
    reg [4:0] sink_quiet_q;
    reg [4:0] out_quiet_q;
    reg [4:0] pins_q;
    wire [4:0] pins_d;
    assign pins_d = {serial_clk_i, load_strobe_i, drive_gate_n_i,
                     hold_i, error_mode_i};
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pins_q <= 5'h00;
            sink_quiet_q <= 5'h00;
            out_quiet_q <= 5'h00;
        end else begin
            pins_q <= pins_d;
            if (pins_d[3:0] != pins_q[3:0]) begin
                sink_quiet_q <= 5'h00;
            end else if (sink_quiet_q != 5'h1F) begin
                sink_quiet_q <= sink_quiet_q + 5'h01;
            end
            if ({pins_d[4:3], pins_d[0]} != {pins_q[4:3], pins_q[0]}) begin
                out_quiet_q <= 5'h00;
            end else if (out_quiet_q != 5'h1F) begin
                out_quiet_q <= out_quiet_q + 5'h01;
            end
        end
    end
    sequence gate_held_s;
        drive_gate_n_i [*5];
    endsequence
    sequence lowcur_held_s;
        (error_mode_o == 3'h4) [*2];
    endsequence
    gate_off_a: assert property (
        gate_held_s |-> sink_outputs_o == 16'h0)
        else $error("sinks on while gate high");
    sink_hold_a: assert property (
        sink_quiet_q > 5'h10 |-> $stable(sink_outputs_o))
        else $error("sinks moved without load or gate");
    out_quiet_a: assert property (
        out_quiet_q > 5'h08 |-> $stable(serial_out_o))
        else $error("serial out moved without clock");
    mode_range_a: assert property (error_mode_o <= 3'h4)
        else $error("mode out of range");
    mode_step_a: assert property (
        $changed(error_mode_o) && error_mode_o != 3'h0
        |-> error_mode_o == $past(error_mode_o) + 3'h1)
        else $error("mode skipped");
    err_out_high_a: assert property (
        error_mode_o != 3'h0 && $past(error_mode_o) != 3'h0
        |-> serial_out_o) else $error("serial out low");
    lowcur_on_a: assert property (lowcur_held_s |-> low_current_o)
        else $error("low current not flagged");
    diag_idle_a: assert property (
        !error_mode_i [*5] |-> diag_result_o == 16'h0)
        else $error("diag shown outside error mode");
endmodule

// File: test/lsd_top_tb.sv
// Self-checking bench for the LED sink driver core
`timescale 1ns/1ps
module lsd_top_tb;
    reg clk_sys_i;
    reg rst_i;
    reg drive_gate_n_i;
    reg error_mode_i;
    reg hold_i;
    reg [15:0] fault_open_i;
    reg [15:0] fault_short_i;
    reg [15:0] fault_temp_i;
    wire serial_clk_i;
    wire serial_in_i;
    wire load_strobe_i;
    wire [15:0] sink_outputs_o;
    wire serial_out_o;
    wire load_ready_o;
    wire low_current_o;
    wire [2:0] error_mode_o;
    wire [15:0] diag_result_o;
    integer miscompares = 0;
    integer compares = 0;
    lsd_host lsd_host_i (.clk_sys_i(clk_sys_i), .serial_clk_o(serial_clk_i),
        .serial_in_o(serial_in_i), .load_strobe_o(load_strobe_i));
    lsd_top lsd_top_i (.*);
    task chk(input string name, input [15:0] exp, input [15:0] got);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("unexpected %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task end_sim;
        begin
            $display("compares %0d miscompares %0d", compares, miscompares);
            if (miscompares == 0 && compares > 0) begin
                $display("SIMULATION PASSED");
            end else begin
                $display("SIMULATION FAILED");
            end
            $finish;
        end
    endtask
    task t_shift_load;
        begin
            // Bits 7, 8 and 9 differ, so a wrong chain tap shows
            lsd_host_i.send(16'hA543);
            repeat (6) @(posedge clk_sys_i);
            chk("chain", 16'h1, {15'h0, serial_out_o});
            chk("sinks", 16'h0, sink_outputs_o);
            lsd_host_i.load;
            chk("sinks", 16'hA543, sink_outputs_o);
            lsd_host_i.send(16'h5A3C);
            repeat (6) @(posedge clk_sys_i);
            chk("chain", 16'h0, {15'h0, serial_out_o});
            chk("sinks", 16'hA543, sink_outputs_o);
            lsd_host_i.load;
            chk("sinks", 16'h5A3C, sink_outputs_o);
        end
    endtask
    task t_gate;
        begin
            drive_gate_n_i <= 1'b1;
            repeat (5) @(posedge clk_sys_i);
            chk("gate", 16'h0, sink_outputs_o);
            drive_gate_n_i <= 1'b0;
            repeat (5) @(posedge clk_sys_i);
            chk("gate", 16'h5A3C, sink_outputs_o);
        end
    endtask
    // Eight queued words fill the buffer; the ninth must be dropped
    task t_fifo;
        integer k;
        begin
            hold_i <= 1'b1;
            for (k = 1; k <= 9; k = k + 1) begin
                lsd_host_i.send({4{k[3:0]}});
                lsd_host_i.load;
            end
            chk("ready", 16'h0, {15'h0, load_ready_o});
            chk("held", 16'h5A3C, sink_outputs_o);
            hold_i <= 1'b0;
            repeat (30) @(posedge clk_sys_i);
            chk("drained", 16'h8888, sink_outputs_o);
            chk("ready", 16'h1, {15'h0, load_ready_o});
        end
    endtask
    task t_error;
        reg [15:0] want [1:3];
        integer m;
        begin
            want[1] = 16'h0010;
            want[2] = 16'h0200;
            want[3] = 16'h4000;
            error_mode_i <= 1'b1;
            fault_open_i <= 16'h0010;
            fault_short_i <= 16'h0200;
            fault_temp_i <= 16'h4000;
            repeat (4) @(posedge clk_sys_i);
            lsd_host_i.load;
            chk("global", 16'h0, {15'h0, serial_out_o});
            chk("sinks", 16'h8888, sink_outputs_o);
            for (m = 1; m <= 4; m = m + 1) begin
                lsd_host_i.clk_bit(1'b0);
                repeat (2) @(posedge clk_sys_i);
                chk("mode", m[15:0], {13'h0, error_mode_o});
                if (m < 4) begin
                    chk("diag", want[m], diag_result_o);
                end
            end
            chk("lowcur", 16'h1, {15'h0, low_current_o});
            drive_gate_n_i <= 1'b1;
            repeat (5) @(posedge clk_sys_i);
            chk("gate", 16'h0, sink_outputs_o);
            drive_gate_n_i <= 1'b0;
            fault_open_i <= 16'h0;
            fault_short_i <= 16'h0;
            fault_temp_i <= 16'h0;
            lsd_host_i.clk_bit(1'b0);
            repeat (4) @(posedge clk_sys_i);
            chk("mode", 16'h0, {13'h0, error_mode_o});
            chk("lowcur", 16'h0, {15'h0, low_current_o});
            lsd_host_i.load;
            chk("global", 16'h1, {15'h0, serial_out_o});
            error_mode_i <= 1'b0;
        end
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        rst_i = 1'b1;
        drive_gate_n_i = 1'b0;
        error_mode_i = 1'b0;
        hold_i = 1'b0;
        fault_open_i = 16'h0;
        fault_short_i = 16'h0;
        fault_temp_i = 16'h0;
        repeat (10) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        t_shift_load;
        t_gate;
        t_fifo;
        t_error;
        end_sim;
    end
    // Whole run needs about 2000 cycles
    initial begin
        repeat (10000) @(posedge clk_sys_i);
        miscompares = miscompares + 1;
        end_sim;
    end
endmodule
bind lsd_top lsd_top_chk lsd_top_chk_i (.*);
